// >>> dv/tb.sv
// self-checking bench of the trigger control
// assumes the design's apb slave; the sequencer model answers in nine cycles
`timescale 1ns/1ps
`default_nettype none
`include "trig_defs.svh"

module tb;
    import trig_pkg::*;
    // =====================================================================
    // signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trig = 1'b0;
    logic [2:0] src = 3'h7;
    logic [7:0] trigger_pins;
    seq_req_s seq_req;
    logic seq_done = 1'b0;
    logic trigger_overrun_flag;
    logic irq;
    logic watch_gap = 1'b0;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int checked = 0;
    int starts = 0;
    int gaps = 0;
    int cnt = 0;
    int b = 0;
    int lat = 0;

    always #12.5 clk = ~clk;

    adc_external_trigger_control u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_pins(trigger_pins),
        .seq_req(seq_req), .seq_done(seq_done), .trigger_overrun_flag(trigger_overrun_flag),
        .irq(irq));
    trig_source u_src (.clk(clk), .trig(trig), .sel(src), .pins(trigger_pins));

    // =====================================================================
    // sequencer model, start counter, gap watch
    always @(posedge clk)
    begin
        seq_done <= 1'b0;
        if (watch_gap && seq_done === 1'b1 && seq_req.start !== 1'b1)
            gaps <= gaps + 1;
        if (seq_req.start === 1'b1)
        begin
            starts <= starts + 1;
            cnt <= 8;
        end
        else if (cnt != 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
                seq_done <= 1'b1;
        end
    end

    // =====================================================================
    // helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wait_start();
        lat = 0;
        while (seq_req.start !== 1'b1 && lat < 8)
        begin
            @(negedge clk);
            lat++;
        end
        chk("latency", 32'(lat <= 3), 32'h0000_0001);
    endtask : wait_start

    function automatic logic [31:0] ctrl(input logic e, l, p, s);
        return {25'h0, 3'h7, s, p, l, e};
    endfunction : ctrl

    // =====================================================================
    // scenarios
    task automatic t_regs();
        apb(1'b0, `OFF_CTRL, 0);
        chk("ctrl reset", rd, 32'h0000_0070);
        chk("flag reset", {31'h0, trigger_overrun_flag}, 32'h0000_0000);
        apb(1'b0, 12'h020, 0);
        chk("unmapped err", {31'h0, err}, 32'h0000_0001);
        chk("unmapped data", rd, 32'h0000_0000);
    endtask : t_regs

    task automatic t_soft();
        apb(1'b1, `OFF_CTRL, ctrl(0, 0, 0, 0));
        b = starts;
        apb(1'b1, `OFF_START, 1);
        trig <= 1'b1;
        cyc(6);
        trig <= 1'b0;
        cyc(24);
        chk("single starts", starts - b, 1);
        chk("mask off", {24'h0, seq_req.ignore_mask}, 32'h0000_0000);
        apb(1'b0, `OFF_STATUS, 0);
        chk("status idle", rd, 32'h0000_0000);
        apb(1'b0, `OFF_IRQ_STATUS, 0);
        chk("done flag", {31'h0, rd[0]}, 32'h0000_0001);
    endtask : t_soft

    task automatic t_scan();
        apb(1'b1, `OFF_CTRL, ctrl(0, 0, 0, 1));
        b = starts;
        gaps = 0;
        apb(1'b1, `OFF_START, 1);
        watch_gap <= 1'b1;
        trig <= 1'b1;
        cyc(40);
        apb(1'b0, `OFF_STATUS, 0);
        chk("scan running", {31'h0, rd[2]}, 32'h0000_0001);
        watch_gap <= 1'b0;
        trig <= 1'b0;
        apb(1'b1, `OFF_CTRL, ctrl(0, 0, 0, 0));
        cyc(20);
        chk("scan starts", 32'(starts - b >= 5), 32'h0000_0001);
        chk("scan gaps", gaps, 0);
    endtask : t_scan

    task automatic t_edge(input logic pol);
        trig <= ~pol;
        apb(1'b1, `OFF_CTRL, ctrl(1, 0, pol, pol));
        cyc(6);
        b = starts;
        apb(1'b1, `OFF_START, 1);
        cyc(15);
        chk("start ignored", starts - b, 0);
        trig <= pol;
        wait_start();
        chk("mask trigger", {24'h0, seq_req.ignore_mask}, 32'h0000_0080);
        cyc(20);
        trig <= ~pol;
        cyc(20);
        chk("edge starts", starts - b, 1);
    endtask : t_edge

    task automatic t_overrun();
        apb(1'b1, `OFF_IRQ_CLEAR, 3);
        apb(1'b1, `OFF_IRQ_ENABLE, 0);
        trig <= 1'b1;
        cyc(2);
        trig <= 1'b0;
        cyc(2);
        trig <= 1'b1;
        cyc(6);
        @(negedge clk);
        chk("overrun set", {31'h0, trigger_overrun_flag}, 32'h0000_0001);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        cyc(30);
        @(negedge clk);
        chk("overrun sticky", {31'h0, trigger_overrun_flag}, 32'h0000_0001);
        apb(1'b1, `OFF_IRQ_ENABLE, 2);
        chk("irq on", {31'h0, irq}, 32'h0000_0001);
        apb(1'b0, `OFF_IRQ_STATUS, 0);
        chk("irq status", {31'h0, rd[1]}, 32'h0000_0001);
        apb(1'b1, `OFF_IRQ_CLEAR, 2);
        chk("overrun cleared", {31'h0, trigger_overrun_flag}, 32'h0000_0000);
        chk("irq off", {31'h0, irq}, 32'h0000_0000);
        trig <= 1'b0;
    endtask : t_overrun

    task automatic t_level(input logic pol);
        trig <= ~pol;
        apb(1'b1, `OFF_CTRL, ctrl(1, 1, pol, 0));
        apb(1'b1, `OFF_IRQ_CLEAR, 3);
        cyc(5);
        b = starts;
        gaps = 0;
        trig <= pol;
        wait_start();
        watch_gap <= 1'b1;
        cyc(4);
        trig <= ~pol;
        cyc(2);
        trig <= pol;
        cyc(40);
        @(negedge clk);
        chk("level no overrun", {31'h0, trigger_overrun_flag}, 32'h0000_0000);
        watch_gap <= 1'b0;
        cyc(1);
        trig <= ~pol;
        cyc(20);
        chk("level gaps", gaps, 0);
        chk("level starts", 32'(starts - b >= 5), 32'h0000_0001);
        b = starts;
        cyc(20);
        chk("level stops", starts - b, 0);
    endtask : t_level

    task automatic t_source();
        apb(1'b1, `OFF_CTRL, 32'h0000_0020);
        src <= 3'h2;
        apb(1'b1, `OFF_CTRL, 32'h0000_0025);
        cyc(4);
        b = starts;
        trig <= 1'b1;
        wait_start();
        chk("mask source", {24'h0, seq_req.ignore_mask}, 32'h0000_0004);
        cyc(20);
        chk("source starts", starts - b, 1);
        trig <= 1'b0;
    endtask : t_source

    // =====================================================================
    // end of run
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    initial
    begin
        #(25 * 20000);
        miscompares++;
        conclude();
    end

    initial
    begin
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
        t_regs();
        t_soft();
        t_scan();
        t_edge(1'b0);
        t_edge(1'b1);
        t_overrun();
        t_level(1'b0);
        t_level(1'b1);
        t_source();
        conclude();
    end
endmodule : tb
`default_nettype wire

// >>> dv/trig_source.sv
// external event source model feeding the trigger pins
// assumes the bench sets the wanted trigger level just after a rising edge
`timescale 1ns/1ps
`default_nettype none

module trig_source (
    // clock
    input wire logic clk,
    // wanted trigger level and selected channel
    input wire logic trig,
    input wire logic [2:0] sel,
    // pins
    output logic [7:0] pins
);
    // =====================================================================
    // unselected channels carry unrelated activity
    logic [7:0] noise = 8'h55;

    always @(posedge clk)
    begin
        noise <= ~noise;
    end

    always_comb
    begin
        pins = noise;
        pins[sel] = trig;
    end
endmodule : trig_source
`default_nettype wire

// >>> rtl/adc_external_trigger_control.sv
// trigger control of the analog_converter: decides when sequences start
// assumes an apb master, a sequencer that pulses seq_done per sequence
// Behaviour
// - trigger off, no scan: one sequence per start
// - trigger off, scan: back to back sequences
// - edge mode: one sequence per selected edge
// - level mode: convert while trigger active
// - extra edges during conversion set overrun in edge mode
// - first conversion two cycles after a trigger pin change (synchroniser delay)
// - source resets to channel seven, channel ignored while trigger enabled
// - start register ignored while trigger enabled
// - level mode glitches never set overrun
// - level still active at done: restart immediately
`timescale 1ns/1ps
`default_nettype none
`include "trig_defs.svh"

module adc_external_trigger_control (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trigger pins, analog channels seen digitally
    input wire logic [7:0] trigger_pins,
    // conversion sequencer
    output var trig_pkg::seq_req_s seq_req,
    input wire logic seq_done,
    // flags
    output logic trigger_overrun_flag,
    output logic irq
);
    import trig_pkg::*;

    // =====================================================================
    // reset release
    logic rst_ff1;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_ff1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_ff1 <= 1'b1;
            rst_sync_n <= rst_ff1;
        end
    end

    // =====================================================================
    // address decode
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : addr_hit

    ctrl_s ctrl;
    seq_state_e state;
    logic scan_run;
    logic [`IRQ_HI:0] irq_status;
    logic [`IRQ_HI:0] irq_enable;
    logic [7:0] ignore_mask;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire sel_ctrl = addr_hit(paddr, `OFF_CTRL);
    wire sel_start = addr_hit(paddr, `OFF_START);
    wire sel_status = addr_hit(paddr, `OFF_STATUS);
    wire sel_istat = addr_hit(paddr, `OFF_IRQ_STATUS);
    wire sel_iclr = addr_hit(paddr, `OFF_IRQ_CLEAR);
    wire sel_ien = addr_hit(paddr, `OFF_IRQ_ENABLE);
    wire mapped = sel_ctrl | sel_start | sel_status | sel_istat | sel_iclr | sel_ien;
    wire wr_ok = access & pwrite & mapped;
    wire wr_ctrl = wr_ok & sel_ctrl;
    wire wr_start = wr_ok & sel_start;
    wire wr_clear = wr_ok & sel_iclr;
    wire wr_ien = wr_ok & sel_ien;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // =====================================================================
    // read mux
    wire [`STAT_HI:0] status_bits = {scan_run, irq_status[`IRQ_OVR], state == ST_CONVERT};
    wire [31:0] rd_data =
        sel_ctrl ? {25'h000_0000, ctrl} :
        sel_status ? {29'h0000_0000, status_bits} :
        sel_istat ? {30'h0000_0000, irq_status} :
        sel_ien ? {30'h0000_0000, irq_enable} :
        `WORD_ZERO;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            prdata <= `WORD_ZERO;
        else if (setup & ~pwrite)
            prdata <= rd_data;
    end

    // =====================================================================
    // control registers
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ctrl <= ctrl_s'(`CTRL_RESET);
        else if (wr_ctrl)
            ctrl <= ctrl_s'(pwdata[`CTRL_SRC_HI:0]);
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_enable <= `IRQ_RESET;
        else if (wr_ien)
            irq_enable <= pwdata[`IRQ_HI:0];
    end

    // =====================================================================
    // trigger synchronisation and detection
    logic trig_level;
    logic trig_rise;
    logic trig_fall;

    trig_sync u_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .pins(trigger_pins),
        .sel(ctrl.src_sel),
        .level(trig_level),
        .rise(trig_rise),
        .fall(trig_fall)
    );

    wire ete = ctrl.external_trigger_enable;
    wire lvl = ctrl.trigger_level_select;
    wire active_lvl = ctrl.trigger_polarity ? trig_level : ~trig_level;
    wire active_edge = ctrl.trigger_polarity ? trig_rise : trig_fall;

    // =====================================================================
    // start decision
    wire busy = state == ST_CONVERT;
    wire done_evt = busy & seq_done;
    wire can_start = ~busy | seq_done;
    wire sw_go = wr_start & ~ete;
    wire ext_want = lvl ? active_lvl : active_edge;
    wire sw_want = sw_go | scan_run;
    wire want = ete ? ext_want : sw_want;
    wire start = can_start & want;
    wire overrun_evt = ete & ~lvl & active_edge & busy & ~seq_done;
    wire next_scan_run = ctrl.scan & ~ete & (scan_run | sw_go);

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            scan_run <= 1'b0;
        else
            scan_run <= next_scan_run;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            state <= ST_IDLE;
        else
        begin
            case (state)
                ST_IDLE: state <= start ? ST_CONVERT : ST_IDLE;
                ST_CONVERT: state <= (seq_done & ~start) ? ST_IDLE : ST_CONVERT;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // =====================================================================
    // interrupt flags, set wins over clear
    wire [`IRQ_HI:0] irq_evt = {overrun_evt, done_evt};
    wire [`IRQ_HI:0] irq_clr = wr_clear ? pwdata[`IRQ_HI:0] : `IRQ_RESET;
    wire [`IRQ_HI:0] next_irq_status = (irq_status & ~irq_clr) | irq_evt;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_status <= `IRQ_RESET;
        else
            irq_status <= next_irq_status;
    end

    assign trigger_overrun_flag = irq_status[`IRQ_OVR];
    assign irq = |(irq_status & irq_enable);

    // =====================================================================
    // trigger channel result mask
    wire [7:0] next_ignore_mask = ete ? (`MASK_ONE << ctrl.src_sel) : `MASK_ZERO;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ignore_mask <= `MASK_ZERO;
        else
            ignore_mask <= next_ignore_mask;
    end

    assign seq_req.start = start;
    assign seq_req.ignore_mask = ignore_mask;

    // =====================================================================
    // checks
    property p_single_stop;
        @(posedge clk) disable iff (!rst_sync_n)
        (!ete && !scan_run && done_evt && !wr_start) |-> !seq_req.start;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single sequence restarted");

    property p_scan_b2b;
        @(posedge clk) disable iff (!rst_sync_n)
        (!ete && scan_run && done_evt) |-> seq_req.start;
    endproperty
    a_scan_b2b: assert property (p_scan_b2b)
        else $error("scan did not restart");

    property p_edge_start;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && !lvl && active_edge && !busy) |-> seq_req.start;
    endproperty
    a_edge_start: assert property (p_edge_start)
        else $error("edge did not start sequence");

    property p_edge_only;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && !lvl && seq_req.start) |-> active_edge;
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("edge mode start without edge");

    property p_level_run;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && lvl && active_lvl && can_start) |-> seq_req.start;
    endproperty
    a_level_run: assert property (p_level_run)
        else $error("level mode not converting");

    property p_ovr_set;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && !lvl && active_edge && busy && !seq_done) |=> trigger_overrun_flag;
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("overrun not flagged");

    property p_latency;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && !lvl && !busy && $stable(ctrl) && $rose(trig_level) && ctrl.trigger_polarity)
            |-> seq_req.start;
    endproperty
    a_latency: assert property (p_latency)
        else $error("start late after trigger");

    property p_mask;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && !wr_ctrl) |=> (seq_req.ignore_mask == (`MASK_ONE << ctrl.src_sel));
    endproperty
    a_mask: assert property (p_mask)
        else $error("trigger channel mask wrong");

    property p_sw_ignored;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && wr_start && !busy && !ext_want) |-> !seq_req.start;
    endproperty
    a_sw_ignored: assert property (p_sw_ignored)
        else $error("software start while trigger enabled");

    property p_level_no_ovr;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && lvl && !trigger_overrun_flag) |=> !trigger_overrun_flag;
    endproperty
    a_level_no_ovr: assert property (p_level_no_ovr)
        else $error("overrun in level mode");

    property p_ovr_hold;
        @(posedge clk) disable iff (!rst_sync_n)
        (trigger_overrun_flag && !(wr_clear && pwdata[`IRQ_OVR])) |=> trigger_overrun_flag;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("overrun flag lost");

    property p_busy_after_start;
        @(posedge clk) disable iff (!rst_sync_n)
        seq_req.start |=> busy;
    endproperty
    a_busy_after_start: assert property (p_busy_after_start)
        else $error("not busy after start");

    property p_sw_start;
        @(posedge clk) disable iff (!rst_sync_n)
        (!ete && wr_start && !busy) |-> seq_req.start;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start dropped");

    property p_done_idle;
        @(posedge clk) disable iff (!rst_sync_n)
        (done_evt && !seq_req.start) |=> !busy;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("still busy after last sequence");

    property p_trig_ignored;
        @(posedge clk) disable iff (!rst_sync_n)
        (!ete && !wr_start && !scan_run) |-> !seq_req.start;
    endproperty
    a_trig_ignored: assert property (p_trig_ignored)
        else $error("start while trigger disabled and idle");

    property p_level_stop;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && lvl && !active_lvl) |-> !seq_req.start;
    endproperty
    a_level_stop: assert property (p_level_stop)
        else $error("level mode start while inactive");

    property p_level_b2b;
        @(posedge clk) disable iff (!rst_sync_n)
        (ete && lvl && active_lvl && done_evt) |-> seq_req.start;
    endproperty
    a_level_b2b: assert property (p_level_b2b)
        else $error("level mode gap after sequence");

    property p_mask_off;
        @(posedge clk) disable iff (!rst_sync_n)
        (!ete && !wr_ctrl) |=> (seq_req.ignore_mask == `MASK_ZERO);
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("channel masked while trigger disabled");

endmodule : adc_external_trigger_control

`default_nettype wire

// >>> rtl/dummy_unused_never.sv
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> rtl/trig_defs.svh
// register offsets, field positions and reset values of the trigger control
// assumes inclusion by bare name from the design files
`ifndef TRIG_DEFS_SVH
`define TRIG_DEFS_SVH

// =====================================================================
// apb register byte offsets
`define OFF_CTRL 12'h000
`define OFF_START 12'h004
`define OFF_STATUS 12'h008
`define OFF_IRQ_STATUS 12'h00C
`define OFF_IRQ_CLEAR 12'h010
`define OFF_IRQ_ENABLE 12'h014

// =====================================================================
// control register fields
`define CTRL_ETE 0
`define CTRL_LVL 1
`define CTRL_POL 2
`define CTRL_SCAN 3
`define CTRL_SRC_LO 4
`define CTRL_SRC_HI 6
`define CTRL_RESET 7'h70

// =====================================================================
// status and interrupt fields
`define STAT_BUSY 0
`define STAT_OVR 1
`define STAT_RUN 2
`define STAT_HI 2
`define IRQ_DONE 0
`define IRQ_OVR 1
`define IRQ_HI 1
`define IRQ_RESET 2'h0

// =====================================================================
// misc constants
`define WORD_ZERO 32'h0000_0000
`define MASK_ZERO 8'h00
`define MASK_ONE 8'h01

`endif

// >>> rtl/trig_pkg.sv
// types shared by the trigger control design
// assumes the defs header is compiled alongside
`default_nettype none
package trig_pkg;

    // =====================================================================
    // control register layout, msb first
    typedef struct packed {
        logic [2:0] src_sel;
        logic scan;
        logic trigger_polarity;
        logic trigger_level_select;
        logic external_trigger_enable;
    } ctrl_s;

    // =====================================================================
    // request towards the conversion sequencer
    typedef struct packed {
        logic start;
        logic [7:0] ignore_mask;
    } seq_req_s;

    // =====================================================================
    // sequencer tracking state
    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } seq_state_e;

endpackage : trig_pkg

`default_nettype wire

// >>> rtl/trig_sync.sv
// trigger pin synchroniser and edge detector
// assumes pins are asynchronous; output edges are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module trig_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and selection
    input wire logic [7:0] pins,
    input wire logic [2:0] sel,
    // detected trigger
    output logic level,
    output logic rise,
    output logic fall
);

    // =====================================================================
    // two flop synchroniser per pin
    logic [7:0] meta;
    logic [7:0] stab;
    logic prev;
    wire sel_level = stab[sel];

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_sync
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta[i] <= 1'b0;
                    stab[i] <= 1'b0;
                end
                else
                begin
                    meta[i] <= pins[i];
                    stab[i] <= meta[i];
                end
            end
        end
    endgenerate

    // =====================================================================
    // edge detection on the selected line
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev <= 1'b0;
        else
            prev <= sel_level;
    end

    assign level = sel_level;
    assign rise = sel_level & ~prev;
    assign fall = ~sel_level & prev;

endmodule : trig_sync

`default_nettype wire
